// *** hdl/axil_reg_slave.sv ***
/*
  Minimal AXI4-Lite slave front end: accepts one write and one read at
  a time and hands single-cycle strobes to the register file.
  Assumes a well-behaved master; address and data may come in any order.
*/
`timescale 1ns/10ps
module axil_reg_slave (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // AXI4-Lite
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Register file side
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic             rd_en,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);
  import rail_supervisor_pkg::*;

  logic       aw_have_r, w_have_r;
  logic [7:0] awaddr_r, araddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic       rd_pend_r;

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
  assign wr_en   = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_addr = awaddr_r;
  assign wr_data = wdata_r;
  assign wr_strb = wstrb_r;

  // Capture each half, commit once both are held
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_have_r    <= 1'b0;
      w_have_r     <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign s_axi_arready = !rd_pend_r && !s_axi_rvalid;
  assign rd_en   = rd_pend_r;
  assign rd_addr = araddr_r;

  // Address in one cycle, data the next; one read in flight
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_pend_r    <= 1'b0;
      araddr_r     <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend_r <= 1'b1;
        araddr_r  <= s_axi_araddr;
      end
      if (rd_pend_r) begin
        rd_pend_r    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok ? rd_data : 32'h0000_0000;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// *** hdl/multi_rail_reset_supervisor.sv ***
/*
  Top level of the multi-rail reset supervisor: per-rail fault outputs,
  the combined system reset with its release timeout, the override
  input, tolerance band select, and an AXI4-Lite register file with
  sticky interrupts.
  Assumes comparator results arrive already synchronous to clk_sys,
  high meaning the rail is above threshold.
*/
`timescale 1ns/10ps

// What this block does
// - Holding the override input low forces every fault output and the system reset high.
// - Each rail fault output follows its own rail one clock later, low when under threshold.
// - System reset is low while any rail is low or manual reset is pulled low.
// - After every cause clears, system reset stays low for the full timeout, then goes high.
// - Band select low chooses the 5 percent band, high the 10 percent band, held static.
// - Manual reset is active low: low requests reset, high is released.
// - With timeout set tied high the internal timeout of at least 140 ms is used.
module multi_rail_reset_supervisor #(
  parameter int unsigned TIMEOUT_CYC = rail_supervisor_pkg::RESET_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Rail comparators, high when above threshold
  input  wire logic        supply_sense_1,
  input  wire logic        supply_sense_2,
  input  wire logic        supply_sense_3,
  input  wire logic        supply_sense_4,
  // Control pins
  input  wire logic        manual_reset_n,
  input  wire logic        override_n,
  input  wire logic        threshold_band_select,
  input  wire logic        timeout_set,
  // Supervisor outputs
  output logic             rail_fault_1_n,
  output logic             rail_fault_2_n,
  output logic             rail_fault_3_n,
  output logic             rail_fault_4_n,
  output logic             sys_reset_n,
  output logic             band_10pct,
  output logic             irq,
  // AXI4-Lite
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import rail_supervisor_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sense_t               sense;
  logic [NUM_RAILS-1:0] fault_n_r;
  logic [NUM_RAILS-1:0] rail_ok_d_r;
  logic                 sys_reset_n_r;
  logic                 hold_d_r;
  logic                 band_r;
  logic                 irq_r;
  logic [31:0]          ctrl_r;
  logic [IRQ_W-1:0]     irq_status_r;
  logic [IRQ_W-1:0]     irq_status_nxt;
  logic [IRQ_W-1:0]     irq_mask_r;
  logic [IRQ_W-1:0]     events;
  logic                 cause_any;
  logic                 hold_reset;
  seq_state_t           seq_state;
  logic                 wr_en, rd_en, wr_ok, rd_ok;
  logic [7:0]           wr_addr, rd_addr;
  logic [31:0]          wr_data, rd_data;
  logic [3:0]           wr_strb;

  assign sense.rail_ok    = {supply_sense_4, supply_sense_3,
                             supply_sense_2, supply_sense_1};
  assign sense.manual_n   = manual_reset_n;
  assign sense.band_10    = threshold_band_select;
  assign sense.override_n = override_n;

  // ----------------------------------------------------------------
  // Reset causes
  // ----------------------------------------------------------------
  // Timer enable off or timeout pin low keeps the internal timer out;
  // the capacitor timeout is not modelled, so reset then stays held.
  assign cause_any = !(&sense.rail_ok)
                   || !sense.manual_n
                   || !timeout_set
                   || !ctrl_r[CTRL_TIMER_EN_BIT];

  reset_timeout_seq #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_seq (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .cause_any  (cause_any),
    .state      (seq_state),
    .hold_reset (hold_reset)
  );

  // ----------------------------------------------------------------
  // Per-rail fault outputs
  // ----------------------------------------------------------------
  // One register stage only, so outputs come from flops
  genvar g;
  generate
    for (g = 0; g < NUM_RAILS; g++) begin : g_rail
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          fault_n_r[g] <= 1'b1;
        end else begin
          fault_n_r[g] <= sense.rail_ok[g] || !sense.override_n;
        end
      end
    end
  endgenerate

  assign rail_fault_1_n = fault_n_r[0];
  assign rail_fault_2_n = fault_n_r[1];
  assign rail_fault_3_n = fault_n_r[2];
  assign rail_fault_4_n = fault_n_r[3];

  // ----------------------------------------------------------------
  // System reset and band select
  // ----------------------------------------------------------------
  // Reset held low from power-up until the sequencer lets go;
  // cause also gates directly so it reaches the pin within one clock
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sys_reset_n_r <= 1'b0;
    end else begin
      sys_reset_n_r <= !sense.override_n
                    || (!hold_reset && !cause_any);
    end
  end

  // Band is a static strap; it is just reflected for the comparators
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      band_r <= 1'b0;
    end else begin
      band_r <= sense.band_10;
    end
  end

  assign sys_reset_n = sys_reset_n_r;
  assign band_10pct  = band_r;

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rail_ok_d_r <= '1;
      hold_d_r    <= 1'b1;
    end else begin
      rail_ok_d_r <= sense.rail_ok;
      hold_d_r    <= hold_reset;
    end
  end

  assign events = {hold_d_r && !hold_reset,
                   !hold_d_r && hold_reset,
                   rail_ok_d_r & ~sense.rail_ok};

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    irq_status_nxt = irq_status_r;
    if (wr_en && wr_addr == ADDR_IRQ_STATUS && wr_strb[0]) begin
      irq_status_nxt = irq_status_r & ~wr_data[IRQ_W-1:0];
    end
    irq_status_nxt = irq_status_nxt | events;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_status_r <= IRQ_RESET_VAL;
      irq_r        <= 1'b0;
    end else begin
      irq_status_r <= irq_status_nxt;
      irq_r        <= |(irq_status_nxt & irq_mask_r);
    end
  end

  assign irq = irq_r;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  axil_reg_slave u_bus (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_ok         (wr_ok),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  // Status is read-only; a write there is answered with an error
  assign wr_ok = (wr_addr == ADDR_CTRL) || (wr_addr == ADDR_IRQ_STATUS)
              || (wr_addr == ADDR_IRQ_MASK);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_r     <= CTRL_RESET_VAL;
      irq_mask_r <= IRQ_RESET_VAL;
    end else if (wr_en && wr_strb[0]) begin
      if (wr_addr == ADDR_CTRL) begin
        ctrl_r[CTRL_TIMER_EN_BIT] <= wr_data[CTRL_TIMER_EN_BIT];
      end
      if (wr_addr == ADDR_IRQ_MASK) begin
        irq_mask_r <= wr_data[IRQ_W-1:0];
      end
    end
  end

  // Read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (rd_addr)
      ADDR_CTRL:       rd_data = ctrl_r;
      ADDR_STATUS: begin
        rd_data[NUM_RAILS-1:0]   = fault_n_r;
        rd_data[ST_SYS_RESET_BIT] = sys_reset_n_r;
        rd_data[ST_MANUAL_BIT]   = sense.manual_n;
        rd_data[ST_BAND_BIT]     = band_r;
        rd_data[ST_OVERRIDE_BIT] = sense.override_n;
        rd_data[ST_TIMING_BIT]   = (seq_state == ST_TIMING);
      end
      ADDR_IRQ_STATUS: rd_data[IRQ_W-1:0] = irq_status_r;
      ADDR_IRQ_MASK:   rd_data[IRQ_W-1:0] = irq_mask_r;
      default:         rd_ok = 1'b0;
    endcase
  end

endmodule

// *** hdl/rail_supervisor_pkg.sv ***
/*
  Shared constants and types for the multi-rail reset supervisor:
  register offsets, field layouts, reset values, timing and states.
  Assumes a single 250 MHz clock and an AXI4-Lite register bus.
*/
package rail_supervisor_pkg;

  // ----------------------------------------------------------------
  // Rails and timing
  // ----------------------------------------------------------------
  localparam int unsigned NUM_RAILS        = 4;
  localparam int unsigned CLK_FREQ_HZ      = 250_000_000;
  localparam int unsigned RESET_TIMEOUT_MS = 140;
  // Least time: ms times clock kHz, exact at 250 MHz, no round-up
  localparam int unsigned RESET_TIMEOUT_CYC =
    (RESET_TIMEOUT_MS * (CLK_FREQ_HZ / 1000) + 0) ;
  localparam int unsigned CNT_W            = 32;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h0c;

  // Control fields
  localparam int unsigned CTRL_TIMER_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET_VAL    = 32'h0000_0001;

  // Status fields
  localparam int unsigned ST_SYS_RESET_BIT = 4;
  localparam int unsigned ST_MANUAL_BIT    = 5;
  localparam int unsigned ST_BAND_BIT      = 6;
  localparam int unsigned ST_OVERRIDE_BIT  = 7;
  localparam int unsigned ST_TIMING_BIT    = 8;

  // Interrupt events: rail falls [3:0], reset asserted, reset released
  localparam int unsigned IRQ_W            = 6;
  localparam int unsigned IRQ_ASSERT_BIT   = 4;
  localparam int unsigned IRQ_RELEASE_BIT  = 5;
  localparam logic [IRQ_W-1:0] IRQ_RESET_VAL = 6'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HOLD    = 2'b00,
    ST_TIMING  = 2'b01,
    ST_RELEASE = 2'b11
  } seq_state_t;

  typedef struct packed {
    logic [NUM_RAILS-1:0] rail_ok;
    logic                 manual_n;
    logic                 band_10;
    logic                 override_n;
  } sense_t;

endpackage

// *** hdl/reset_timeout_seq.sv ***
/*
  Release sequencer: holds system reset while any cause is present,
  then counts the full timeout before letting go.
  Assumes the cause level is synchronous to clk_sys.
*/
`timescale 1ns/10ps
module reset_timeout_seq #(
  parameter int unsigned TIMEOUT_CYC = rail_supervisor_pkg::RESET_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst_n,
  // Cause in, reset out
  input  wire logic                                  cause_any,
  output rail_supervisor_pkg::seq_state_t            state,
  output logic                                       hold_reset
);
  import rail_supervisor_pkg::*;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT_CYC - 1);

  seq_state_t       state_r;
  logic [CNT_W-1:0] count_r;

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  // A returning cause throws away the partial count
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= ST_HOLD;
      count_r <= '0;
    end else if (cause_any) begin
      state_r <= ST_HOLD;
      count_r <= '0;
    end else begin
      case (state_r)
        ST_HOLD: begin
          state_r <= ST_TIMING;
          count_r <= '0;
        end
        ST_TIMING: begin
          if (count_r == LAST) begin
            state_r <= ST_RELEASE;
          end else begin
            count_r <= count_r + 1'b1;
          end
        end
        ST_RELEASE: state_r <= ST_RELEASE;
        default:    state_r <= ST_HOLD;
      endcase
    end
  end

  assign state      = state_r;
  assign hold_reset = (state_r != ST_RELEASE);

endmodule

// *** verification/rail_env_model.sv ***
/*
  Far-side model: rail comparators, reset button and band strap.
  Assumes the bench commands levels at a rising edge of clk_sys.
*/
`timescale 1ns/10ps
module rail_env_model (
  // Clock
  input  wire logic       clk_sys,
  // Commands from the bench
  input  wire logic [3:0] rail_cmd,
  input  wire logic       mr_cmd_n,
  input  wire logic       band_cmd,
  input  wire logic [2:0] lag,
  // Pins toward the supervisor
  output logic            supply_sense_1,
  output logic            supply_sense_2,
  output logic            supply_sense_3,
  output logic            supply_sense_4,
  output logic            manual_reset_n,
  output logic            threshold_band_select
);
  logic [4:0] hist_r [0:7];

  // ------------
  // Pins
  // ------------
  // Start healthy so no pin is ever unknown
  initial begin
    {manual_reset_n, supply_sense_4, supply_sense_3} = 3'h7;
    {supply_sense_2, supply_sense_1} = 2'h3;
    threshold_band_select = 1'b0;
    for (int i = 0; i < 8; i++) hist_r[i] = 5'h1f;
  end
  // A slow rail settles lag cycles late
  always @(posedge clk_sys) begin
    for (int i = 7; i > 0; i--) hist_r[i] <= hist_r[i-1];
    hist_r[0] <= {mr_cmd_n, rail_cmd};
    {manual_reset_n, supply_sense_4, supply_sense_3, supply_sense_2,
     supply_sense_1} <= (lag == 3'h0) ? {mr_cmd_n, rail_cmd}
                                      : hist_r[lag-3'h1];
    threshold_band_select <= band_cmd;
  end
endmodule

// *** verification/supervisor_asserts.sv ***
/*
  Checker on the supervisor pins: faults, reset timing, override, band.
  Assumes the timer enable bit stays at its reset value of one.
*/
`timescale 1ns/10ps
module supervisor_asserts #(
  parameter int unsigned TIMEOUT_CYC = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pins
  input wire logic supply_sense_1,
  input wire logic supply_sense_2,
  input wire logic supply_sense_3,
  input wire logic supply_sense_4,
  input wire logic manual_reset_n,
  input wire logic override_n,
  input wire logic threshold_band_select,
  input wire logic timeout_set,
  input wire logic rail_fault_1_n,
  input wire logic rail_fault_2_n,
  input wire logic rail_fault_3_n,
  input wire logic rail_fault_4_n,
  input wire logic sys_reset_n,
  input wire logic band_10pct
);
  logic [3:0]  rails;
  logic [3:0]  faults_n;
  logic        all_clear;
  int unsigned clr_cnt_r;

  assign rails = {supply_sense_4, supply_sense_3, supply_sense_2,
                  supply_sense_1};
  assign faults_n = {rail_fault_4_n, rail_fault_3_n, rail_fault_2_n,
                     rail_fault_1_n};
  assign all_clear = (&rails) && manual_reset_n && timeout_set;

  // Clear cycles in a row, saturating
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !all_clear) clr_cnt_r <= 0;
    else if (clr_cnt_r < TIMEOUT_CYC + 8) clr_cnt_r <= clr_cnt_r + 1;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ------------
  // Assertions
  // ------------
  AST_OVERRIDE_HIGH: assert property (
    !override_n |=> (&faults_n) && sys_reset_n)
    else $error("override ignored");
  AST_FAULT_FOLLOW: assert property (
    override_n |=> faults_n == $past(rails))
    else $error("fault pin wrong");
  AST_CAUSE_ASSERTS: assert property (
    override_n && !all_clear |=> !sys_reset_n)
    else $error("reset missed a cause");
  AST_HOLD_FULL: assert property (
    $past(override_n) && clr_cnt_r <= TIMEOUT_CYC |-> !sys_reset_n)
    else $error("reset released early");
  AST_RELEASE_BY: assert property (
    $past(override_n) && clr_cnt_r >= TIMEOUT_CYC + 4 |-> sys_reset_n)
    else $error("reset released late");
  AST_BAND_COPY: assert property (
    threshold_band_select != band_10pct |=>
      band_10pct == $past(threshold_band_select))
    else $error("band copy wrong");
  AST_STRAP_LOW: assert property (
    override_n && !timeout_set |=> !sys_reset_n)
    else $error("strap low ignored");
  AST_RECUR_RESTART: assert property (
    override_n && $fell(all_clear) |=>
      (!sys_reset_n || !$past(override_n)) [*8])
    else $error("reset dropped on recurrence");
endmodule

bind multi_rail_reset_supervisor supervisor_asserts #(
  .TIMEOUT_CYC(TIMEOUT_CYC)
) u_chk (
  .clk_sys, .rst_n, .supply_sense_1, .supply_sense_2, .supply_sense_3,
  .supply_sense_4, .manual_reset_n, .override_n, .threshold_band_select,
  .timeout_set, .rail_fault_1_n, .rail_fault_2_n, .rail_fault_3_n,
  .rail_fault_4_n, .sys_reset_n, .band_10pct
);

// *** verification/tb_top.sv ***
/*
  Bench: cycle model of the pins, register and interrupt tests.
  Assumes rail_env_model drives the rail and button pins.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import rail_supervisor_pkg::*;
  localparam int T = 20;
  logic clk_sys = 0, rst_n = 0, override_n = 1, timeout_set = 1;
  logic [3:0] rail_cmd = 4'hf, s_axi_wstrb = 4'hf;
  logic mr_cmd_n = 1, band_cmd = 0;
  logic [2:0] lag = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [1:0] rsp;
  wire supply_sense_1, supply_sense_2, supply_sense_3;
  wire supply_sense_4, manual_reset_n, threshold_band_select;
  wire rail_fault_1_n, rail_fault_2_n, rail_fault_3_n;
  wire rail_fault_4_n, sys_reset_n, band_10pct, irq;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int n_checks = 0, miscompares = 0, cyc_cnt = 0, mcnt = 0;
  logic p_rst = 0, p_ovr = 1;
  logic [3:0] p_rails = 4'hf;
  wire [3:0] rails = {supply_sense_4, supply_sense_3,
                      supply_sense_2, supply_sense_1};
  wire [3:0] faults = {rail_fault_4_n, rail_fault_3_n,
                       rail_fault_2_n, rail_fault_1_n};

  always #2 clk_sys = ~clk_sys;

  rail_env_model env (.clk_sys, .rail_cmd, .mr_cmd_n, .band_cmd, .lag,
    .supply_sense_1, .supply_sense_2, .supply_sense_3, .supply_sense_4,
    .manual_reset_n, .threshold_band_select);
  multi_rail_reset_supervisor #(.TIMEOUT_CYC(T)) dut (.clk_sys, .rst_n,
    .supply_sense_1, .supply_sense_2, .supply_sense_3, .supply_sense_4,
    .manual_reset_n, .override_n, .threshold_band_select, .timeout_set,
    .rail_fault_1_n, .rail_fault_2_n, .rail_fault_3_n, .rail_fault_4_n,
    .sys_reset_n, .band_10pct, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // ------------
  // Cycle model
  // ------------
  // Skip the cycles where release may land
  always @(posedge clk_sys) begin
    if (p_rst) begin
      `CHK("faults", p_ovr ? p_rails : 4'hf, faults)
      if (!p_ovr) `CHK("sysrst_ovr", 1'b1, sys_reset_n)
      else if (mcnt <= T) `CHK("sysrst_hold", 1'b0, sys_reset_n)
      else if (mcnt >= T + 4) `CHK("sysrst_rel", 1'b1, sys_reset_n)
    end
    p_rst = rst_n;
    p_ovr = override_n;
    p_rails = rails;
    mcnt = (!rst_n || !((&rails) && manual_reset_n && timeout_set)) ? 0
           : mcnt + 1;
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ------------
  // Tasks
  // ------------
  task automatic end_of_test();
    $display("Checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask
  task automatic wait_rel(input string s);
    cyc(4);
    while (sys_reset_n !== 1'b1) @(posedge clk_sys);
    cyc(2);
    $display("Test %s done, checks %0d", s, n_checks);
  endtask

  // ------------
  // Scenarios
  // ------------
  initial begin
    void'($urandom(32'hce400d46));
    cyc(16);
    `CHK("rst_sys", 1'b0, sys_reset_n)
    rst_n <= 1'b1;
    // Reset values and refused accesses
    rdc(ADDR_CTRL, CTRL_RESET_VAL, RESP_OKAY);
    rdc(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
    rdc(8'h10, 32'h0, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h0);
    `CHK("bresp_ro", RESP_SLVERR, rsp)
    wr(ADDR_IRQ_MASK, 32'hffff_ffff);
    rdc(ADDR_IRQ_MASK, 32'h3f, RESP_OKAY);
    wait_rel("powerup");
    rdc(ADDR_STATUS, 32'h0bf, RESP_OKAY);
    // Interrupt set, mask, clear
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h3f);
    cyc(1);
    `CHK("irq_idle", 1'b0, irq)
    rail_cmd <= 4'he;
    cyc(4);
    `CHK("irq_set", 1'b1, irq)
    wr(ADDR_IRQ_MASK, 32'h0);
    cyc(1);
    `CHK("irq_masked", 1'b0, irq)
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h1);
    cyc(1);
    `CHK("irq_clr", 1'b0, irq)
    rail_cmd <= 4'hf;
    wait_rel("irq");
    rdc(ADDR_IRQ_STATUS, 32'h30, RESP_OKAY);
    wr(ADDR_IRQ_STATUS, 32'h3f);
    // Single rails, then random mixes, random lag
    for (int i = 0; i < 8; i++) begin
      lag <= 3'($urandom_range(0, 3));
      rail_cmd <= (i < 4) ? ~(4'h1 << i) : 4'($urandom_range(0, 14));
      cyc(2 + $urandom_range(0, 6));
      rail_cmd <= 4'hf;
      wait_rel("rail");
    end
    // Cause back mid-count
    mr_cmd_n <= 1'b0;
    cyc(3);
    mr_cmd_n <= 1'b1;
    cyc(T / 2);
    mr_cmd_n <= 1'b0;
    cyc(2);
    mr_cmd_n <= 1'b1;
    wait_rel("restart");
    // Override over rail and manual reset causes
    rail_cmd <= 4'($urandom_range(0, 14));
    mr_cmd_n <= 1'b0;
    override_n <= 1'b0;
    cyc(T + 10);
    override_n <= 1'b1;
    mr_cmd_n <= 1'b1;
    rail_cmd <= 4'hf;
    wait_rel("override");
    // Band select copy
    band_cmd <= 1'b1;
    cyc(3);
    `CHK("band", 1'b1, band_10pct)
    rdc(ADDR_STATUS, 32'h0bf | (32'h1 << ST_BAND_BIT), RESP_OKAY);
    band_cmd <= 1'b0;
    // Timeout strap low holds reset
    timeout_set <= 1'b0;
    cyc(T + 10);
    `CHK("strap", 1'b0, sys_reset_n)
    timeout_set <= 1'b1;
    wait_rel("strap");
    end_of_test();
  end
endmodule
